/* File: logic/adc_conversion_sequencer.v */
/*
  Control and sequencing for a ten-bit successive-approximation
  converter with an eight-way analog multiplexer, plus its register
  file and a level interrupt.
  Assumes: one clock sys_clk; machCycle is a one-cycle enable pulse
  from the core marking the end of each machine cycle; all inputs are
  synchronous to sys_clk; the analog comparator output is settled by
  the last strobe of each bit period.
*/
// Implementation choice: strobed register access.
`include "adc_seq_defs.vh"

module adc_conversion_sequencer
(
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  machCycle,
  input  wire                  idleMode,
  input  wire                  powerDown,
  input  wire                  extStartPin,
  input  wire                  compareHigh,
  input  wire [`ADDR_W-1:0]    regAddr,
  input  wire [`DATA_W-1:0]    regWrData,
  input  wire                  regWr,
  input  wire                  regRd,
  output reg  [`DATA_W-1:0]    regRdData,
  output reg                   irq,
  output reg  [`CHAN_W-1:0]    muxSel,
  output reg                   sampleHold,
  output reg  [`RES_W-1:0]     dacCode
);

  // Address match, shared by the write and read decoders.
  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  reg  [`ST_W-1:0]      state_q;
  reg  [`ST_W-1:0]      state_d;
  reg  [`CNT_W-1:0]     cnt_q;
  reg  [`CNT_W-1:0]     cnt_d;
  reg  [`BIT_IDX_W-1:0] bitIdx_q;
  reg  [`BIT_IDX_W-1:0] bitIdx_d;
  reg  [`RES_W-1:0]     trial_q;
  reg  [`RES_W-1:0]     trial_d;
  reg  [`RES_W-1:0]     result_q;
  reg  [`RES_W-1:0]     result_d;
  reg                   busy_q;
  reg                   busy_d;
  reg                   done_q;
  reg                   done_d;
  reg                   extEn_q;
  reg                   extPrev_q;
  reg                   pending_q;
  reg                   pending_d;
  reg                   pendExt_q;
  reg                   pendExt_d;
  reg  [`CHAN_W-1:0]    chan_q;
  reg  [`INT_W-1:0]     intStat_q;
  reg  [`INT_W-1:0]     intEn_q;
  reg                   finish;
  reg                   lostStart;

  wire wrCtrl  = regWr & hit(regAddr, `REG_CTRL);
  wire wrClear = regWr & hit(regAddr, `REG_INT_CLEAR);
  wire wrEn    = regWr & hit(regAddr, `REG_INT_ENABLE);
  wire abort   = idleMode | powerDown;
  wire blocked = done_q | busy_q | pending_q;

  // Software start: clearing done in the same write is honoured, so
  // the done term uses the written bit rather than the stored one.
  wire swReq    = wrCtrl & regWrData[`CTRL_BUSY];
  wire swStart  = swReq & ~regWrData[`CTRL_DONE]
                  & ~busy_q & ~pending_q;
  // External edge is sampled only at the end of a machine cycle.
  wire extEdge  = machCycle & extStartPin & ~extPrev_q;
  wire extReq   = extEdge & extEn_q;
  wire extStart = extReq & ~blocked & ~swStart;

  // Start pin history, advanced once per machine cycle.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      extPrev_q <= 1'b0;
    else if (machCycle)
      extPrev_q <= extStartPin;
  end

  // Sequencer: pending start, init, sample, then bit resolution.
  //
  // Timing, counted in machine-cycle strobes after a start is taken:
  //   strobe 0       the pending start is consumed and init begins.
  //   strobes 1..2   two init cycles; busy is forced high at the first.
  //   strobes 3..10  eight sample cycles; sampleHold stands throughout.
  //   strobe 10      the top trial bit is loaded for the first compare.
  //   strobes 11..50 four strobes per bit, bit nine resolved first.
  //   strobe 50      result stored, done set and busy cleared together.
  // The whole conversion therefore spans fifty strobes after the one
  // that begins it, which matches the fixed conversion length.
  //
  // A start is remembered in pending_q until the next strobe, because
  // a register write can land anywhere inside a machine cycle. The
  // pending flag also counts as busy for refusals, so a second start
  // in the same machine cycle is dropped rather than queued.
  //
  // The comparator is only read at the last strobe of each bit
  // period. The trial code on dacCode has been stable for the three
  // strobes before that, which gives the analog side time to settle.
  //
  // Limitation: a zero input voltage still walks all ten trial bits;
  // there is no early exit, so the conversion length never varies.
  always @*
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    bitIdx_d  = bitIdx_q;
    trial_d   = trial_q;
    result_d  = result_q;
    busy_d    = busy_q;
    pending_d = pending_q;
    pendExt_d = pendExt_q;
    finish    = 1'b0;
    lostStart = (swReq & ~swStart) | (extReq & ~extStart);
    if (swStart)
    begin
      pending_d = 1'b1;
      pendExt_d = 1'b0;
      busy_d    = 1'b1;
    end
    else if (extStart)
    begin
      pending_d = 1'b1;
      pendExt_d = 1'b1;
    end
    case (state_q)
      `ST_IDLE:
      begin
        // Begin in the machine cycle after the request was taken.
        if (pending_q && machCycle)
        begin
          state_d   = `ST_INIT;
          cnt_d     = {`CNT_W{1'b0}};
          pending_d = 1'b0;
        end
      end
      `ST_INIT:
      begin
        if (machCycle)
        begin
          busy_d = 1'b1;
          if (cnt_q == `INIT_CYCLES - 6'h01)
          begin
            state_d = `ST_SAMPLE;
            cnt_d   = {`CNT_W{1'b0}};
          end
          else
            cnt_d = cnt_q + 6'h01;
        end
      end
      `ST_SAMPLE:
      begin
        if (machCycle)
        begin
          if (cnt_q == `SAMPLE_CYCLES - 6'h01)
          begin
            state_d  = `ST_CONV;
            cnt_d    = {`CNT_W{1'b0}};
            bitIdx_d = `TOP_BIT;
            trial_d  = {`RES_W{1'b0}};
            trial_d[`TOP_BIT] = 1'b1;
          end
          else
            cnt_d = cnt_q + 6'h01;
        end
      end
      `ST_CONV:
      begin
        if (machCycle)
        begin
          if (cnt_q == `BIT_CYCLES - 6'h01)
          begin
            cnt_d = {`CNT_W{1'b0}};
            // Keep the trial bit only if the input is above the DAC.
            trial_d[bitIdx_q] = compareHigh;
            if (bitIdx_q == {`BIT_IDX_W{1'b0}})
            begin
              state_d  = `ST_IDLE;
              busy_d   = 1'b0;
              finish   = 1'b1;
              result_d = trial_d;
            end
            else
            begin
              bitIdx_d = bitIdx_q - 4'h1;
              trial_d[bitIdx_q - 4'h1] = 1'b1;
            end
          end
          else
            cnt_d = cnt_q + 6'h01;
        end
      end
      default:
      begin
        state_d = `ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
    // Power reduction drops the conversion; a held result survives
    // because result_q is only written on completion.
    if (abort)
    begin
      state_d   = `ST_IDLE;
      busy_d    = 1'b0;
      pending_d = 1'b0;
      finish    = 1'b0;
      result_d  = result_q;
    end
  end

  // The done flag: set by completion only, cleared by a zero write.
  // A write of one to this bit has no effect, so software cannot fake
  // a completion and trigger the interrupt on its own.
  // Set wins if completion lands in the clearing write's cycle.
  always @*
  begin
    done_d = done_q;
    if (wrCtrl && !regWrData[`CTRL_DONE])
      done_d = 1'b0;
    if (finish)
      done_d = 1'b1;
  end

  // Sequencer and flag registers.
  // Reset returns the machine to idle with both flags low; the stored
  // result is cleared too so that a read before any conversion is
  // deterministic.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q   <= `ST_IDLE;
      cnt_q     <= {`CNT_W{1'b0}};
      bitIdx_q  <= {`BIT_IDX_W{1'b0}};
      trial_q   <= {`RES_W{1'b0}};
      result_q  <= {`RES_W{1'b0}};
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      pending_q <= 1'b0;
      pendExt_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      bitIdx_q  <= bitIdx_d;
      trial_q   <= trial_d;
      result_q  <= result_d;
      busy_q    <= busy_d;
      done_q    <= done_d;
      pending_q <= pending_d;
      pendExt_q <= pendExt_d;
    end
  end

  // Control bits that software owns. Channel is frozen while a result is
  // held, a start is pending or busy is set, so it can still move in the first init cycle of an external start.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      chan_q  <= {`CHAN_W{1'b0}};
      extEn_q <= 1'b0;
      intEn_q <= {`INT_W{1'b0}};
    end
    else
    begin
      if (wrCtrl)
        extEn_q <= regWrData[`CTRL_EXT_EN];
      if (wrCtrl && !done_q && !busy_q && !pending_q)
        chan_q <= regWrData[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
      if (wrEn)
        intEn_q <= regWrData[`INT_W-1:0];
    end
  end

  // Sticky interrupt status; an event in the clearing cycle stays set.
  // Bit zero records a completed conversion and bit one a start that
  // was discarded because the converter was busy or pending, done was held
  // or written as one, or a software start took the same cycle.
  // Letting the set win means an event can never be lost to a clear
  // that software issued for an earlier one.
  wire [`INT_W-1:0] intEvent = {lostStart, finish};
  genvar g;
  generate
    for (g = 0; g < `INT_W; g = g + 1)
    begin : gSticky
      always @(posedge sys_clk)
      begin
        if (!rst_n)
          intStat_q[g] <= 1'b0;
        else if (intEvent[g])
          intStat_q[g] <= 1'b1;
        else if (wrClear && regWrData[g])
          intStat_q[g] <= 1'b0;
      end
    end
  endgenerate

  // Next status image, so irq follows the sticky bits without lag.
  // Without this look-ahead the registered irq would trail the status
  // register by a cycle and could still read high after a clear.
  reg [`INT_W-1:0] intStat_d;
  always @*
  begin
    intStat_d = intStat_q;
    if (wrClear)
      intStat_d = intStat_d & ~regWrData[`INT_W-1:0];
    intStat_d = intStat_d | intEvent;
  end

  // Control register image, shared by reads.
  // The two low result bits sit at the top, above the external enable,
  // done, busy and the three channel bits.
  wire [`DATA_W-1:0] ctrlImage =
    {result_q[`RES_LO_MSB:0], extEn_q, done_q, busy_q, chan_q};

  // Read port: data stand in the cycle after the strobe only.
  // Unmapped and write-only addresses read as zero.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      regRdData <= {`DATA_W{1'b0}};
    else if (regRd)
    begin
      if (hit(regAddr, `REG_CTRL))
        regRdData <= ctrlImage;
      else if (hit(regAddr, `REG_RESULT_HI))
        regRdData <= result_q[`RES_HI_MSB:`RES_HI_LSB];
      else if (hit(regAddr, `REG_INT_STATUS))
        regRdData <= {{(`DATA_W-`INT_W){1'b0}}, intStat_q};
      else if (hit(regAddr, `REG_INT_ENABLE))
        regRdData <= {{(`DATA_W-`INT_W){1'b0}}, intEn_q};
      else
        regRdData <= {`DATA_W{1'b0}};
    end
    else
      regRdData <= {`DATA_W{1'b0}};
  end

  // Analog-side outputs and the interrupt line, all registered.
  // Taken from the next-state values they add no delay against the sequencer
  // state (muxSel trails chan_q by one), and keep glitches off the analog switches and the core.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irq        <= 1'b0;
      muxSel     <= {`CHAN_W{1'b0}};
      sampleHold <= 1'b0;
      dacCode    <= {`RES_W{1'b0}};
    end
    else
    begin
      irq        <= |(intStat_d & intEn_q);
      muxSel     <= chan_q;
      sampleHold <= (state_d == `ST_SAMPLE);
      dacCode    <= trial_d;
    end
  end

endmodule // adc_conversion_sequencer

/* File: logic/adc_seq_defs.vh */
/*
  Constants for the conversion sequencer: register offsets, field
  positions, widths, state codes and sequence lengths.
  Assumes it is included by bare name from the design and bench files.
*/
// Summary of operation
// - Converts one of eight inputs, ten bits.
// - Whole conversion takes fifty machine cycles.
// - Low three control bits pick channel, binary.
// - Channel changes only while done and busy low.
// - Upper eight bits high register, lower two control.
// - Busy clears as done sets; interrupt if enabled.
// - Done set by hardware only; zero write clears.
// - Writing busy one starts; zero cannot clear.
// - External enable lets start pin edge start.
// - Starts while done or busy are dropped; a software start whose write also clears done is taken.
// - Result held unchanged while done high.
// - Idle or power-down abandons running conversion.
// - Start begins on next machine cycle.
// - Two init cycles; busy after first.
// - Eight sample cycles, four per bit.
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

`define ADDR_W          8
`define DATA_W          8
`define REG_CTRL        8'hc5
`define REG_RESULT_HI   8'hc6
`define REG_INT_STATUS  8'hc7
`define REG_INT_CLEAR   8'hc8
`define REG_INT_ENABLE  8'hc9

`define CTRL_CHAN_LSB   0
`define CTRL_CHAN_MSB   2
`define CTRL_BUSY       3
`define CTRL_DONE       4
`define CTRL_EXT_EN     5
`define CTRL_RES_LSB    6
`define CTRL_RES_MSB    7

`define CHAN_W          3
`define RES_W           10
`define RES_HI_LSB      2
`define RES_HI_MSB      9
`define RES_LO_MSB      1
`define INT_W           2
`define INT_DONE        0
`define INT_LOST        1

`define INIT_CYCLES     6'h02
`define SAMPLE_CYCLES   6'h08
`define BIT_CYCLES      6'h04
`define CNT_W           6
`define BIT_IDX_W       4
`define TOP_BIT         4'h9

`define ST_IDLE         4'h1
`define ST_INIT         4'h2
`define ST_SAMPLE       4'h4
`define ST_CONV         4'h8
`define ST_W            4

`endif

/* File: testbench/adc_analog_model.sv */
/*
  Analog side of the converter: machine-cycle strobe and comparator.
  Assumes vin is held steady by the bench through each conversion.
*/
module adc_analog_model
(
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire [9:0] vin,
  input  wire [9:0] dacCode,
  output logic      machCycle = 1'b0,
  output logic      compareHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q = 2'h0;

  // One strobe every fourth clock, like the core's cycle end.
  always @(posedge sys_clk)
  begin
    div_q     <= rst_n ? div_q + 2'h1 : 2'h0;
    machCycle <= rst_n && (div_q == 2'h3);
  end

  // An ideal comparator, so a good conversion returns vin exactly.
  assign compareHigh = (vin >= dacCode);
endmodule // adc_analog_model

/* File: testbench/adc_conversion_sequencer_monitor.sv */
/*
  Port-level checker for the conversion sequencer, bound into it.
  Assumes one clock and a synchronous active-low reset.
*/
`include "adc_seq_defs.vh"
module adc_conversion_sequencer_monitor
(
  input wire               sys_clk,
  input wire               rst_n,
  input wire               machCycle,
  input wire               idleMode,
  input wire               powerDown,
  input wire [`ADDR_W-1:0] regAddr,
  input wire               regWr,
  input wire               regRd,
  input wire [`DATA_W-1:0] regRdData,
  input wire               irq,
  input wire [`CHAN_W-1:0] muxSel,
  input wire               sampleHold,
  input wire [`RES_W-1:0]  dacCode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] smpCnt_q;
  wire        quiet = !(idleMode || powerDown);

  // Strobes seen while sampling; an abort would cut it short.
  always @(posedge sys_clk)
    smpCnt_q <= (rst_n && sampleHold) ? smpCnt_q + {3'h0, machCycle} : 4'h0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // End of a sampling window with no abort nearby.
  sequence sCleanFall;
    quiet ##1 ($fell(sampleHold) && quiet);
  endsequence

  AST_SAMPLE_LEN: assert property (sCleanFall |->
    smpCnt_q == 4'h8) else $error("sample window was not eight strobes");
  AST_FIRST_TRIAL: assert property (sCleanFall |->
    dacCode == 10'h200) else $error("first trial code is not the top bit");
  AST_SAMPLE_START: assert property ($rose(sampleHold) |->
    $past(machCycle)) else $error("sampling began off a strobe");
  AST_MUX_HOLD: assert property (sampleHold |-> $stable(muxSel))
    else $error("channel moved while sampling");
  AST_RD_IDLE: assert property (!$past(regRd) |->
    regRdData == 8'h00) else $error("read data outside its slot");
  AST_CLR_READ: assert property (regRd &&
    regAddr == `REG_INT_CLEAR |=> regRdData == 8'h00)
    else $error("clear register read non-zero");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(regWr) ||
    $past(regWr, 2) || $past(regWr, 3)) else $error("irq fell unprompted");
  AST_DAC_STEP: assert property ($changed(dacCode) |->
    $past(machCycle) || $past(regWr) || !$past(quiet) || !$past(quiet, 2))
    else $error("trial code moved off a strobe");
endmodule // adc_conversion_sequencer_monitor

bind adc_conversion_sequencer adc_conversion_sequencer_monitor u_mon (.*);

/* File: testbench/adc_conversion_sequencer_tb.sv */
/*
  Bench for the conversion sequencer: register tasks, a queued read
  checker and scenarios for starts, refusals, masking and aborts.
  Assumes the analog model gives a strobe every fourth clock.
*/
`include "adc_seq_defs.vh"
module adc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       idleMode = 1'b0;
  logic       powerDown = 1'b0;
  logic       extStartPin = 1'b0;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic       rdSeen = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [7:0] m;
  logic [9:0] vin = 10'h000;
  logic [9:0] dacCode;
  logic [2:0] muxSel;
  logic [2:0] ch = 3'h0;
  logic       irq;
  logic       machCycle;
  logic       compareHigh;
  logic       sampleHold;
  logic [7:0] expQ[$];
  logic [7:0] mskQ[$];
  int         err_count = 0;
  int         cmp_count = 0;
  int         c;
  int         n;

  adc_conversion_sequencer dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .machCycle(machCycle), .idleMode(idleMode), .powerDown(powerDown),
    .extStartPin(extStartPin), .compareHigh(compareHigh),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .irq(irq), .muxSel(muxSel),
    .sampleHold(sampleHold), .dacCode(dacCode));
  adc_analog_model model (.sys_clk(sys_clk), .rst_n(rst_n), .vin(vin),
    .dacCode(dacCode), .machCycle(machCycle), .compareHigh(compareHigh));

  // Bench clock, 4 ns period.
  initial forever #2 sys_clk = ~sys_clk;

  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // The expected value is noted before the strobe goes out.
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] k);
    expQ.push_back(e);
    mskQ.push_back(k);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask

  task automatic sync();
    @(posedge sys_clk);
    for (int i = 0; i < 8 && machCycle !== 1'b1; i++)
      @(posedge sys_clk);
    if (machCycle !== 1'b1)
    begin
      err_count++;
      final_report();
    end
  endtask

  // Counts strobes until lim of them pass or irq rises.
  task automatic waitConv(input int lim, output int k);
    k = 0;
    for (int i = 0; i < 8 * lim && k < lim && irq !== 1'b1; i++)
    begin
      @(posedge sys_clk);
      k += (machCycle === 1'b1);
      @(negedge sys_clk);
    end
  endtask

  // A missing completion is both a mismatch and the end of the run.
  task automatic conv(input int exp);
    waitConv(60, c);
    chk(10'(c), 10'(exp));
    if (irq !== 1'b1)
      final_report();
  endtask

  // The pin must be seen low at one strobe and high at the next.
  task automatic extStart();
    extStartPin <= 1'b0;
    sync();
    extStartPin <= 1'b1;
  endtask

  // Each answer is taken the cycle after its strobe, oldest note first.
  always @(posedge sys_clk)
  begin
    if (rdSeen === 1'b1)
    begin
      m = mskQ.pop_front();
      chk({2'h0, regRdData & m}, {2'h0, expQ.pop_front() & m});
    end
    rdSeen <= regRd;
  end

  initial
  begin
    void'($urandom(21));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 6; n++)
      rd(8'(`REG_CTRL + n), 8'h00, 8'hff);
    rd(8'h00, 8'h00, 8'hff);
    $display("Test done: reset values");
    wr(`REG_INT_ENABLE, 8'h01);
    for (n = 0; n < 8; n++)
    begin
      ch = 3'(n);
      vin <= 10'($urandom);
      wr(`REG_CTRL, {5'h00, ch});
      sync();
      wr(`REG_CTRL, {5'h01, ch});
      conv(51);
      chk({7'h00, muxSel}, {7'h00, ch});
      rd(`REG_RESULT_HI, vin[9:2], 8'hff);
      rd(`REG_CTRL, {vin[1:0], 3'h2, ch}, 8'hff);
      wr(`REG_CTRL, {5'h03, ~ch});
      rd(`REG_CTRL, {vin[1:0], 3'h2, ch}, 8'hff);
      rd(`REG_INT_STATUS, 8'h03, 8'hff);
      wr(`REG_INT_CLEAR, 8'h03);
      rd(`REG_INT_STATUS, 8'h00, 8'hff);
      @(negedge sys_clk);
      chk({9'h000, irq}, 10'h000);
      wr(`REG_CTRL, {5'h00, ch});
      rd(`REG_CTRL, {vin[1:0], 3'h0, ch}, 8'hff);
    end
    $display("Test done: software conversions on every channel");
    extStart();
    waitConv(60, c);
    rd(`REG_CTRL, {5'h00, ch}, 8'h3f);
    wr(`REG_CTRL, {5'h04, ch});
    vin <= 10'($urandom);
    extStart();
    conv(52);
    rd(`REG_RESULT_HI, vin[9:2], 8'hff);
    $display("Test done: external start");
    wr(`REG_INT_CLEAR, 8'h03);
    wr(`REG_INT_ENABLE, 8'h00);
    vin <= 10'($urandom);
    wr(`REG_CTRL, {5'h01, ch});
    rd(`REG_CTRL, {5'h01, ch}, 8'h3f);
    waitConv(60, c);
    chk({9'h000, irq}, 10'h000);
    rd(`REG_INT_STATUS, 8'h01, 8'hff);
    rd(`REG_RESULT_HI, vin[9:2], 8'hff);
    wr(`REG_INT_ENABLE, 8'h01);
    repeat (3) @(negedge sys_clk);
    chk({9'h000, irq}, 10'h001);
    $display("Test done: masked interrupt and same-write restart");
    for (n = 0; n < 2; n++)
    begin
      wr(`REG_INT_CLEAR, 8'h03);
      wr(`REG_CTRL, {5'h00, ch});
      sync();
      wr(`REG_CTRL, {5'h01, ch});
      waitConv(20, c);
      wr(`REG_CTRL, {5'h00, ~ch});
      rd(`REG_CTRL, {5'h01, ch}, 8'h3f);
      idleMode <= (n == 0);
      powerDown <= (n == 1);
      waitConv(2, c);
      idleMode <= 1'b0;
      powerDown <= 1'b0;
      rd(`REG_CTRL, {5'h00, ch}, 8'h3f);
      waitConv(60, c);
      rd(`REG_INT_STATUS, 8'h00, 8'hff);
    end
    $display("Test done: abort by idle and power-down");
    repeat (2) @(posedge sys_clk);
    final_report();
  end
endmodule // adc_conversion_sequencer_tb
